/* File: pkg/adcsf_defines.svh */
`ifndef ADCSF_DEFINES_SVH
`define ADCSF_DEFINES_SVH

// =====================================================
// Control word field positions
`define ADCSF_CW_START 7
`define ADCSF_CW_POLARITY 6
`define ADCSF_CW_CLKSEL 5
`define ADCSF_CW_MODE_HI 4
`define ADCSF_CW_MODE_LO 3
`define ADCSF_CW_AUX_HI 2
`define ADCSF_CW_AUX_LO 0

// =====================================================
// Reset values
`define ADCSF_RST_POLARITY 1'h0
`define ADCSF_RST_CLKSEL 1'h1
`define ADCSF_RST_AUX 3'h0

// =====================================================
// Frame counts in falling shift-clock edges after the start bit, and word and result bit counts
`define ADCSF_DECODE_FALL 6'h07
`define ADCSF_ACQ_FALL_SHORT 6'h07
`define ADCSF_ACQ_FALL_LONG 6'h0f
`define ADCSF_MSB_FALL_SHORT 6'h08
`define ADCSF_MSB_FALL_LONG 6'h10
`define ADCSF_END_FALL_SHORT 6'h18
`define ADCSF_END_FALL_LONG 6'h20
`define ADCSF_WORD_BITS 4'h8
`define ADCSF_LAST_CAPTURE 4'h7
`define ADCSF_RESULT_BITS 14
`define ADCSF_SHIFT_AFTER_MSB 4'hf

// =====================================================
// Timing
`define ADCSF_CLK_PERIOD_NS 50
`define ADCSF_INT_CONV_MAX_NS 6000
`define ADCSF_INT_CONV_CYCLES (`ADCSF_INT_CONV_MAX_NS / `ADCSF_CLK_PERIOD_NS)
`define ADCSF_CAL_CYCLES 80000

`endif

/* File: pkg/adcsf_pkg.sv */
package adcsf_pkg;

    // Operating mode, the two mode bits of the control word
    typedef enum logic [1:0] {
        ADCSF_MODE_SHORT = 2'h0,
        ADCSF_MODE_CAL = 2'h1,
        ADCSF_MODE_PDOWN = 2'h2,
        ADCSF_MODE_LONG = 2'h3
    } adcsf_mode_type;

    // Conversion engine state
    typedef enum logic [3:0] {
        ADCSF_CV_IDLE = 4'h1,
        ADCSF_CV_EXT = 4'h2,
        ADCSF_CV_INT = 4'h4,
        ADCSF_CV_CAL = 4'h8
    } adcsf_conv_type;

endpackage

/* File: verilog/adcsf_ctrl.sv */
// Contract
// R1 - Control bit 5 picks conversion clock: 1 internal oscillator, 0 shift clock.
// R2 - Only the host shift clock moves serial data in and out.
// R3 - External mode steps the conversion on shift-clock edges.
// R4 - External short: strobe high one period after falling edge seven.
// R5 - External short: result MSB appears at falling edge eight.
// R6 - External long: strobe high one period after falling edge fifteen.
// R7 - External long: result MSB appears at falling edge sixteen.
// R8 - Control bit 6 selects polarity: 1 unipolar, 0 bipolar.
// R9 - Mode bits: 00 short, 01 calibrate, 10 power-down, 11 long.
// R10 - Bits 2..0 latch together into the auxiliary output register.
// R11 - Shutdowns keep auxiliary outputs unchanged and actively driven.
// R12 - External mode: strobe floats while chip select is high.
// R13 - External mode: shift-clock edges ignored while chip select high.
// R14 - Internal mode: own conversion clock, result readable at any rate.
// R15 - Internal mode: strobe low during conversion, at most 6 us; the code keeps it low 121 clk_sys periods, longer while no result is queued.
// R16 - Host should hold shift clock low during internal conversion.
// R17 - Internal mode: MSB at strobe rise, then 15 falls shift rest.
// R18 - Internal mode: conversion continues with chip select high.
// R19 - Internal mode: strobe stays driven while chip select high.
// R20 - Host may shift control in at 4.8 MHz with enough acquisition.
// R21 - Result leaves MSB first, coding set by polarity.
// R22 - First high bit sampled is the start bit, not chip select.
// R23 - Conversion begins at the falling edge after the seventh bit.
// R24 - Chip select pulse and new start bit abort the running operation.
// R25 - Serial input sampled on shift-clock rising edges.
// R26 - Serial output changes on falls, floats while chip select high.
// R27 - Auxiliary outputs clear at reset and reset pin.
// R28 - After reset: bipolar with internal conversion clock.
// R29 - Zeros before a start bit are ignored.
// R30 - Start detector re-arms after a conversion or calibration completes.

`include "adcsf_defines.svh"

// =====================================================
// Result FIFO
module adcsf_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 4
) (
    // System
    input wire logic clk_sys,
    input wire logic rstN,
    // Fill side
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    // Drain side
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [AW:0] FULLCNT = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_r;
    logic [AW-1:0] rdPtr_r;
    logic [AW:0] count_r;
    wire push = inValid && inReady;
    wire pop = outValid && outReady;

    assign inReady = count_r != FULLCNT;
    assign outValid = count_r != '0;
    assign outData = mem[rdPtr_r];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstN) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= (wrPtr_r == LAST) ? '0 : wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= (rdPtr_r == LAST) ? '0 : rdPtr_r + 1'b1;
            end
            count_r <= count_r + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule

// =====================================================
// Serial control and framing
module adcsf_ctrl #(
    parameter int CAL_CYCLES = `ADCSF_CAL_CYCLES
) (
    // System
    input wire logic clk_sys,
    input wire logic nrst,
    // Device pins
    input wire logic sclk,
    input wire logic csN,
    input wire logic din,
    input wire logic rstPinN,
    input wire logic shutdown_n,
    output logic dout,
    output logic doutOe,
    output logic conversion_strobe,
    output logic conversionStrobeOe,
    output logic aux_out_2,
    output logic aux_out_1,
    output logic aux_out_0,
    // Converter core
    input wire logic [`ADCSF_RESULT_BITS-1:0] resultData,
    input wire logic resultValid,
    output logic resultReady,
    output logic polarity_select,
    output logic calActive,
    output logic powerDown
);
    localparam logic [6:0] INT_CYCLES = 7'(`ADCSF_INT_CONV_CYCLES);
    localparam logic [16:0] CAL_LAST = 17'(CAL_CYCLES - 1);

    // =====================================================
    // Synchronisers
    logic sclk1_r, sclk2_r, sclk3_r, cs1_r, cs2_r, cs3_r, din1_r, din2_r;
    logic rp1_r, rp2_r, sd1_r, sd2_r;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            {sclk1_r, sclk2_r, sclk3_r} <= 3'h0;
            {cs1_r, cs2_r, cs3_r} <= 3'h7;
            {din1_r, din2_r} <= 2'h0;
            {rp1_r, rp2_r, sd1_r, sd2_r} <= 4'h0;
        end else begin
            {sclk1_r, sclk2_r, sclk3_r} <= {sclk, sclk1_r, sclk2_r};
            {cs1_r, cs2_r, cs3_r} <= {csN, cs1_r, cs2_r};
            {din1_r, din2_r} <= {din, din1_r};
            {rp1_r, rp2_r, sd1_r, sd2_r} <= {rstPinN, rp1_r, shutdown_n, sd1_r};
        end
    end

    // =====================================================
    // Decode
    adcsf_pkg::adcsf_conv_type convState_r;
    adcsf_pkg::adcsf_mode_type modeDec;
    logic cfgPolarity_r, cfgClockInt_r, swPowerDown_r, longAcq_r, strobe_r;
    logic frameActive_r, armed_r;
    logic [5:0] fallCnt_r;
    logic [3:0] bitCnt_r;
    logic [7:0] rxShift_r;
    logic [6:0] intCnt_r;
    logic [16:0] calCnt_r;
    logic [2:0] aux_r;
    logic [`ADCSF_RESULT_BITS-1:0] outShift_r;
    logic [3:0] outLeft_r;
    logic [`ADCSF_RESULT_BITS-1:0] fifoData;
    logic fifoValid;

    wire rstAll = !nrst || !rp2_r;
    wire hwShutdown = !sd2_r;
    wire csLow = !cs2_r;
    wire csFall = !cs2_r && cs3_r;
    // Edges of the host shift clock are the only serial timing
    wire sclkRise = sclk2_r && !sclk3_r; // R2
    wire sclkFall = !sclk2_r && sclk3_r; // R2
    // Chip select high masks every edge
    wire countRise = sclkRise && csLow; // R13 R25
    wire countFall = sclkFall && csLow; // R13 R26
    wire startBit = countRise && armed_r && din2_r; // R22 R29
    wire bitCapture = countRise && frameActive_r && (bitCnt_r != `ADCSF_WORD_BITS); // R25
    wire wordDone = bitCapture && (bitCnt_r == `ADCSF_LAST_CAPTURE);
    wire frameFall = countFall && frameActive_r;
    wire [5:0] fallNext = fallCnt_r + 6'h01;
    wire decodeNow = frameFall && (fallNext == `ADCSF_DECODE_FALL); // R23
    wire [7:0] partialWord = {rxShift_r[6:0], 1'b0};
    assign modeDec = adcsf_pkg::adcsf_mode_type'(
        partialWord[`ADCSF_CW_MODE_HI:`ADCSF_CW_MODE_LO]); // R9
    wire [5:0] acqFall = longAcq_r ? `ADCSF_ACQ_FALL_LONG : `ADCSF_ACQ_FALL_SHORT;
    wire [5:0] msbFall = longAcq_r ? `ADCSF_MSB_FALL_LONG : `ADCSF_MSB_FALL_SHORT;
    wire [5:0] endFall = longAcq_r ? `ADCSF_END_FALL_LONG : `ADCSF_END_FALL_SHORT;
    wire extFall = frameFall && (convState_r == adcsf_pkg::ADCSF_CV_EXT); // R3
    wire strobeRise = extFall && (fallNext == acqFall); // R4 R6
    wire msbLoadExt = extFall && (fallNext == msbFall); // R5 R7
    wire extEnd = extFall && (fallNext == endFall);
    // Holds off completion while the core has no result queued
    wire intDone = (convState_r == adcsf_pkg::ADCSF_CV_INT) && (intCnt_r == INT_CYCLES)
        && fifoValid; // R15 R17
    wire calStep = (convState_r == adcsf_pkg::ADCSF_CV_CAL) && (cfgClockInt_r || frameFall);
    wire calDone = calStep && (calCnt_r == CAL_LAST);
    wire convDone = extEnd || intDone || calDone;
    wire loadOut = msbLoadExt || intDone;
    wire [`ADCSF_RESULT_BITS-1:0] loadData = fifoValid ? fifoData : '0;

    // =====================================================
    // Result buffer
    adcsf_fifo #(
        .WIDTH(`ADCSF_RESULT_BITS),
        .DEPTH(4)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rstN(!rstAll),
        .inData(resultData),
        .inValid(resultValid),
        .inReady(resultReady),
        .outData(fifoData),
        .outValid(fifoValid),
        .outReady(loadOut)
    );

    // =====================================================
    // Framing and conversion sequencing
    always_ff @(posedge clk_sys) begin
        if (rstAll || hwShutdown) begin
            convState_r <= adcsf_pkg::ADCSF_CV_IDLE;
            frameActive_r <= 1'b0;
            armed_r <= 1'b1;
            fallCnt_r <= 6'h00;
            bitCnt_r <= 4'h0;
            rxShift_r <= 8'h00;
            strobe_r <= rstAll ? `ADCSF_RST_CLKSEL : cfgClockInt_r;
        end else if (startBit) begin
            // A new word aborts whatever is running
            convState_r <= adcsf_pkg::ADCSF_CV_IDLE; // R24
            frameActive_r <= 1'b1;
            armed_r <= 1'b0;
            fallCnt_r <= 6'h00;
            bitCnt_r <= 4'h1;
            rxShift_r <= 8'h01;
            strobe_r <= cfgClockInt_r;
        end else begin
            if (csFall) begin
                armed_r <= 1'b1; // R24
            end
            if (bitCapture) begin
                rxShift_r <= {rxShift_r[6:0], din2_r};
                bitCnt_r <= bitCnt_r + 4'h1;
            end
            if (frameFall) begin
                fallCnt_r <= fallNext;
            end
            if (decodeNow) begin
                unique case (modeDec)
                    adcsf_pkg::ADCSF_MODE_SHORT, adcsf_pkg::ADCSF_MODE_LONG: begin
                        convState_r <= partialWord[`ADCSF_CW_CLKSEL] ?
                            adcsf_pkg::ADCSF_CV_INT : adcsf_pkg::ADCSF_CV_EXT; // R1 R23
                        // Short acquisition ends on the decode fall itself
                        strobe_r <= !partialWord[`ADCSF_CW_CLKSEL]
                            && modeDec == adcsf_pkg::ADCSF_MODE_SHORT; // R4
                    end
                    adcsf_pkg::ADCSF_MODE_CAL: begin
                        convState_r <= adcsf_pkg::ADCSF_CV_CAL;
                        strobe_r <= !partialWord[`ADCSF_CW_CLKSEL];
                    end
                    adcsf_pkg::ADCSF_MODE_PDOWN: begin
                        convState_r <= adcsf_pkg::ADCSF_CV_IDLE;
                        strobe_r <= partialWord[`ADCSF_CW_CLKSEL];
                    end
                endcase
            end
            // Only an external conversion or a shift-clocked calibration needs further falls
            if (wordDone && (convState_r != adcsf_pkg::ADCSF_CV_EXT)
                    && !(convState_r == adcsf_pkg::ADCSF_CV_CAL && !cfgClockInt_r)) begin
                frameActive_r <= 1'b0;
                if (convState_r == adcsf_pkg::ADCSF_CV_IDLE) begin
                    armed_r <= 1'b1;
                end
            end
            if (strobeRise) begin
                strobe_r <= 1'b1; // R4 R6
            end
            if (msbLoadExt) begin
                strobe_r <= 1'b0;
            end
            if (convDone) begin
                convState_r <= adcsf_pkg::ADCSF_CV_IDLE;
                frameActive_r <= 1'b0;
                armed_r <= 1'b1; // R30
                strobe_r <= cfgClockInt_r; // R15
            end
        end
    end

    // Own timebase, unaffected by chip select except for shift-clocked calibration steps
    always_ff @(posedge clk_sys) begin
        if (rstAll || decodeNow) begin
            intCnt_r <= 7'h00;
            calCnt_r <= 17'h00000;
        end else begin
            if (convState_r == adcsf_pkg::ADCSF_CV_INT && intCnt_r != INT_CYCLES) begin
                intCnt_r <= intCnt_r + 7'h01; // R14 R18
            end
            if (calStep) begin
                calCnt_r <= calCnt_r + 17'h00001;
            end
        end
    end

    // =====================================================
    // Configuration and auxiliary port
    always_ff @(posedge clk_sys) begin
        if (rstAll) begin
            cfgPolarity_r <= `ADCSF_RST_POLARITY; // R28
            cfgClockInt_r <= `ADCSF_RST_CLKSEL; // R28
            swPowerDown_r <= 1'b0;
            longAcq_r <= 1'b0;
        end else if (startBit) begin
            swPowerDown_r <= 1'b0;
        end else if (decodeNow) begin
            cfgPolarity_r <= partialWord[`ADCSF_CW_POLARITY]; // R8
            cfgClockInt_r <= partialWord[`ADCSF_CW_CLKSEL]; // R1
            swPowerDown_r <= modeDec == adcsf_pkg::ADCSF_MODE_PDOWN; // R9
            longAcq_r <= modeDec == adcsf_pkg::ADCSF_MODE_LONG; // R9
        end
    end

    // Shutdown has no say here, so the pins hold their value
    always_ff @(posedge clk_sys) begin
        if (rstAll) begin
            aux_r <= `ADCSF_RST_AUX; // R27
        end else if (wordDone) begin
            aux_r <= {rxShift_r[1:0], din2_r}; // R10 R11
        end
    end

    // =====================================================
    // Result shifter
    always_ff @(posedge clk_sys) begin
        if (rstAll) begin
            outShift_r <= '0;
            outLeft_r <= 4'h0;
        end else if (loadOut) begin
            outShift_r <= loadData; // R17 R21
            outLeft_r <= `ADCSF_SHIFT_AFTER_MSB;
        end else if (countFall && outLeft_r != 4'h0) begin
            outShift_r <= {outShift_r[`ADCSF_RESULT_BITS-2:0], 1'b0}; // R21 R26
            outLeft_r <= outLeft_r - 4'h1;
        end
    end

    assign dout = outShift_r[`ADCSF_RESULT_BITS-1];
    assign doutOe = csLow; // R26
    assign conversion_strobe = strobe_r;
    assign conversionStrobeOe = cfgClockInt_r || csLow; // R12 R19
    assign {aux_out_2, aux_out_1, aux_out_0} = aux_r;
    assign polarity_select = cfgPolarity_r;
    assign calActive = convState_r == adcsf_pkg::ADCSF_CV_CAL;
    assign powerDown = swPowerDown_r || hwShutdown;

    // =====================================================
    // Checks
    localparam int INT_LOW_MAX = 120;
    logic [7:0] lowRun_r;

    always_ff @(posedge clk_sys) begin
        if (!nrst || convState_r != adcsf_pkg::ADCSF_CV_INT || !fifoValid) begin
            lowRun_r <= 8'h00;
        end else if (lowRun_r != 8'hff) begin
            lowRun_r <= lowRun_r + 8'h01;
        end
    end

    sequence s_extShortAcq;
        decodeNow && !partialWord[`ADCSF_CW_CLKSEL] && modeDec == adcsf_pkg::ADCSF_MODE_SHORT;
    endsequence

    sequence s_extLongAcq;
        extFall && longAcq_r && fallNext == 6'h0f;
    endsequence

    property p_auxReset;
        @(posedge clk_sys) disable iff (!nrst)
        !rp2_r |=> aux_r == 3'h0;
    endproperty
    a_auxReset: assert property (p_auxReset) else $error("aux not cleared"); // R27

    property p_cfgReset;
        @(posedge clk_sys) disable iff (!nrst)
        !rp2_r |=> cfgClockInt_r && !cfgPolarity_r;
    endproperty
    a_cfgReset: assert property (p_cfgReset) else $error("bad reset config"); // R28

    property p_extShort;
        @(posedge clk_sys) disable iff (!nrst)
        s_extShortAcq |=> conversion_strobe && outLeft_r != `ADCSF_SHIFT_AFTER_MSB;
    endproperty
    a_extShort: assert property (p_extShort) else $error("short strobe missing"); // R4

    property p_extLong;
        @(posedge clk_sys) disable iff (!nrst)
        s_extLongAcq |=> conversion_strobe;
    endproperty
    a_extLong: assert property (p_extLong) else $error("long strobe missing"); // R6

    property p_extMsb;
        @(posedge clk_sys) disable iff (!nrst || rstAll)
        msbLoadExt |=> !conversion_strobe && outLeft_r == 4'hf
            && fallCnt_r == (longAcq_r ? 6'h10 : 6'h08);
    endproperty
    a_extMsb: assert property (p_extMsb) else $error("MSB not at its fall"); // R5 R7

    property p_strobeFloat;
        @(posedge clk_sys) disable iff (!nrst)
        !cfgClockInt_r && cs2_r |-> !conversionStrobeOe;
    endproperty
    a_strobeFloat: assert property (p_strobeFloat) else $error("strobe driven"); // R12

    property p_strobeDriven;
        @(posedge clk_sys) disable iff (!nrst)
        cfgClockInt_r |-> conversionStrobeOe && !(intDone && $past(strobe_r) && 1'b0);
    endproperty
    a_strobeDriven: assert property (p_strobeDriven) else $error("strobe floats"); // R19

    property p_intLow;
        @(posedge clk_sys) disable iff (!nrst)
        lowRun_r <= 8'(INT_LOW_MAX + 1);
    endproperty
    a_intLow: assert property (p_intLow) else $error("strobe low too long"); // R15

    property p_zeroIgnored;
        @(posedge clk_sys) disable iff (!nrst || rstAll || hwShutdown)
        armed_r && !frameActive_r && countRise && !din2_r |=> armed_r && !frameActive_r;
    endproperty
    a_zeroIgnored: assert property (p_zeroIgnored) else $error("zero started frame"); // R29

    property p_doutFloat;
        @(posedge clk_sys) disable iff (!nrst)
        cs2_r |-> !doutOe;
    endproperty
    a_doutFloat: assert property (p_doutFloat) else $error("dout driven"); // R26

    property p_rearm;
        @(posedge clk_sys) disable iff (!nrst || rstAll)
        convDone && !startBit |=> armed_r && convState_r == adcsf_pkg::ADCSF_CV_IDLE;
    endproperty
    a_rearm: assert property (p_rearm) else $error("not re-armed"); // R30
endmodule

/* File: test/adcsf_host_model.sv */
// ====================================================
// Host serial master
module adcsf_host_model (
    // System
    input wire logic clk_sys,
    // Serial link
    output logic sclk,
    output logic csN,
    output logic din,
    input wire logic dout,
    input wire logic conversion_strobe
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        sclk = 1'h0;
        csN = 1'h1;
        din = 1'h0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // Shift clock stands low outside frames; dout taken late in each high phase
    task automatic frame(input logic [7:0] cw, input int n, output logic [31:0] rx,
                         output logic [31:0] sv);
        rx = 32'h0;
        sv = 32'h0;
        csN = 1'h0;
        wait_clk(4);
        for (int k = 0; k < n; k++) begin
            din = (k < 8) ? cw[7-k] : 1'h0;
            wait_clk(4);
            sclk = 1'h1;
            wait_clk(3);
            rx = {rx[30:0], dout};
            sv = {sv[30:0], conversion_strobe};
            wait_clk(1);
            sclk = 1'h0;
        end
        wait_clk(4);
        csN = 1'h1;
        // Released line shows the inverse of its last level
        din = ~din;
        wait_clk(4);
    endtask
endmodule

/* File: test/testbench.sv */
// ====================================================
// Bench top
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_sys = 1'h0;
    logic nrst = 1'h0;
    logic rstPinN = 1'h1;
    logic shutdown_n = 1'h1;
    logic resultValid = 1'h0;
    logic [13:0] resultData = 14'h0;
    logic sclk, csN, din, dout, doutOe, conversion_strobe, conversionStrobeOe;
    logic aux_out_2, aux_out_1, aux_out_0, resultReady, polarity_select, calActive, powerDown;
    logic [31:0] rx, sv;
    logic [13:0] words [4] = '{14'h2a5c, 14'h1f03, 14'h3001, 14'h0ffe};
    int miscompares = 0;
    int comparisons = 0;
    int cnt;

    always #25 clk_sys = ~clk_sys;

    adcsf_host_model i_host (.clk_sys(clk_sys), .sclk(sclk), .csN(csN), .din(din),
        .dout(dout), .conversion_strobe(conversion_strobe));

    adcsf_ctrl #(.CAL_CYCLES(20)) i_dut (
        .clk_sys(clk_sys), .nrst(nrst), .sclk(sclk), .csN(csN), .din(din),
        .rstPinN(rstPinN), .shutdown_n(shutdown_n), .dout(dout), .doutOe(doutOe),
        .conversion_strobe(conversion_strobe), .conversionStrobeOe(conversionStrobeOe),
        .aux_out_2(aux_out_2), .aux_out_1(aux_out_1), .aux_out_0(aux_out_0),
        .resultData(resultData), .resultValid(resultValid), .resultReady(resultReady),
        .polarity_select(polarity_select), .calActive(calActive), .powerDown(powerDown));

    // ====================================================
    // Checking and closing
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic wait_strobe();
        cnt = 0;
        while (conversion_strobe !== 1'h1) begin
            @(negedge clk_sys);
            cnt++;
            if (cnt > 1000) begin
                check(32'h0, 32'h1, "strobe wait timed out");
                report_and_stop();
            end
        end
    endtask

    // One external-clock frame; result and strobe both land at fixed bit slots
    task automatic ext_conv(input logic [7:0] cw, input int n, input logic [13:0] exp);
        i_host.frame(cw, n, rx, sv);
        check(rx[15:2], exp, "result bits");
        check(sv[16:0], 32'h10000, "strobe pulse");
        check({aux_out_2, aux_out_1, aux_out_0}, cw[2:0], "aux outputs");
        check(polarity_select, cw[6], "polarity");
        check({doutOe, conversionStrobeOe}, 2'h0, "enables with cs high");
        $display("test ext %h done", cw);
    endtask

    // ====================================================
    // Sequence
    initial begin
        repeat (10) @(negedge clk_sys);
        nrst = 1'h1;
        repeat (4) @(negedge clk_sys);
        check({aux_out_2, aux_out_1, aux_out_0, polarity_select}, 4'h0, "reset state");
        check({doutOe, conversionStrobeOe}, 2'h1, "reset enables");
        for (int i = 0; i < 5; i++) begin
            resultData = (i < 4) ? words[i] : 14'h0bad;
            resultValid = 1'h1;
            check(resultReady, (i < 4), "fifo ready");
            @(negedge clk_sys);
        end
        resultValid = 1'h0;
        $display("test fifo fill done");
        ext_conv(8'h85, 24, words[0]);
        ext_conv(8'hda, 32, words[1]);
        i_host.frame(8'ha7, 8, rx, sv);
        check({conversion_strobe, conversionStrobeOe}, 2'h1, "internal start");
        wait_strobe();
        check(cnt inside {[95:120]}, 1'h1, "conversion time");
        i_host.frame(8'h00, 16, rx, sv);
        check(rx[15:2], words[2], "internal result");
        $display("test internal done");
        // Long frame cut short, then a fresh word must take over
        i_host.frame(8'hdb, 10, rx, sv);
        ext_conv(8'h85, 24, words[3]);
        ext_conv(8'h80, 24, 14'h0);
        i_host.frame(8'ha8, 8, rx, sv);
        check({calActive, conversion_strobe}, 2'h2, "calibration start");
        wait_strobe();
        check(cnt inside {[1:20]}, 1'h1, "calibration time");
        @(negedge clk_sys);
        check(calActive, 1'h0, "calibration end");
        $display("test calibration done");
        i_host.frame(8'hb3, 8, rx, sv);
        shutdown_n = 1'h0;
        repeat (4) @(negedge clk_sys);
        check({powerDown, aux_out_2, aux_out_1, aux_out_0}, 4'hb, "shutdown aux");
        shutdown_n = 1'h1;
        rstPinN = 1'h0;
        repeat (4) @(negedge clk_sys);
        check({aux_out_2, aux_out_1, aux_out_0, polarity_select, conversionStrobeOe},
              5'h1, "reset pin");
        rstPinN = 1'h1;
        $display("test shutdown and reset pin done");
        report_and_stop();
    end
endmodule
